//--- hdl/link_error_mask_clear.v
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "mask_clear_defs.vh"

// How it works
// [R1] writing 1 to a clear alias drops that mask bit; 0 leaves it
// [R2] reading a clear alias returns current mask bits, not last write
// [R3] each clear alias only touches masks of its own event output
// [R4] events 0 and 1 have per-link a and b clear aliases, links 0-5
// [R5] events 2 and 3 have one shared a and one shared b alias
// [R6] a bits 7,6,4,3: frame range, indicator lost, block edge, frame edge
// [R7] a bit 5 disables the missing comma alarm
// [R8] a bits 2,1,0: decode error, signal loss, sync change
// [R9] b bit 24 disables encoder control-word k-char error
// [R10] b bits 20,17,16: circuit dma out underflow, out overflow, in overflow
// [R11] b bit 18 disables outbound burst overflow
// [R12] b bits 13,12: combiner underflow, combiner overflow
// [R13] b bits 10,9,8: aggregator sum overflow, frame align, header error
// [R14] b bits 3,2,1: tx header error, data misaligned, frame misaligned
// [R15] b bit 0 disables sync change in masked status b
// [R16] common bits 25,24: packet fifo write error, capture ram bus error
// [R17] masks reset to 0; reserved bits read 0
// [R18] set aliases put the same mask bits to 1 on writing 1
// [R19] clear aliases hold no storage; they alias the shared mask words
// [R20] writes to reserved bits change nothing
// [R21] cleared mask gates source from event output; raw status still kept
module link_error_mask_clear #(
    parameter N_LINKS = `N_LINKS
) (
    input  wire                 mclk,
    input  wire                 srst,
    input  wire [11:0]          addr,
    input  wire [31:0]          wdata,
    input  wire                 wr,
    input  wire                 rd,
    output reg  [31:0]          rdata,
    input  wire [N_LINKS*32-1:0] raw_a,
    input  wire [N_LINKS*32-1:0] raw_b,
    input  wire [31:0]          raw_common,
    output reg  [N_LINKS*32-1:0] raw_a_r,
    output reg  [N_LINKS*32-1:0] raw_b_r,
    output reg  [31:0]          raw_common_r,
    output reg  [3:0]           antenna_event_out
);

    // ----------------------------------------
    // address decoding
    // ----------------------------------------
    // word slot: 0..5 per-link (ev0/1) or 0 shared (ev2/3), 6 = common
    localparam SLOT_COMMON = 6;
    localparam NW = 7;

    // returns slot index, or 7 when unmapped
    function [2:0] slot_of;
        input [11:0] a;
        reg   [7:0]  lo;
        begin
            lo = a[7:0] & 8'hfb;
            slot_of = 3'h7;
            if ({4'h0, lo} == `OFF_COMMON) begin
                if (a[2] == 1'b0) slot_of = SLOT_COMMON;
            end else if (lo[3:0] == 4'h0 && lo[7:4] < N_LINKS) begin
                if (a[9] == 1'b0 || lo[7:4] == 4'h0) begin  // [R4] [R5]
                    slot_of = lo[6:4];
                end
            end
        end
    endfunction

    wire [1:0] ev_sel  = addr[9:8];
    wire       is_set  = addr[11];
    wire       is_b    = addr[2];
    wire [2:0] slot    = slot_of(addr);
    wire       aligned = (addr[1:0] == 2'b00) && (addr[10] == 1'b0);
    wire       hit     = aligned && (slot != 3'h7);

    // ----------------------------------------
    // mask storage: one word per event, slot and kind
    // ----------------------------------------
    wire [31:0] m_a [0:`N_EVENTS*NW-1];
    wire [31:0] m_b [0:`N_EVENTS*NW-1];

    genvar e, s;
    generate
        for (e = 0; e < `N_EVENTS; e = e + 1) begin : g_ev
            for (s = 0; s < NW; s = s + 1) begin : g_sl
                // ev2/3 keep only slot 0 and common; other slots never written
                wire sel = hit && wr && (ev_sel == e) && (slot == s);  // [R3]
                wire wa  = sel && !is_b;
                wire wb  = sel && is_b && (s != SLOT_COMMON);
                // common word lives in the a bank
                mask_word #(
                    .VALID((s == SLOT_COMMON) ? `MASK_C_BITS : `MASK_A_BITS)
                ) u_a (
                    .mclk   (mclk),
                    .srst   (srst),
                    .set_we (wa && is_set),   // [R18]
                    .clr_we (wa && !is_set),  // [R1] [R19]
                    .wdata  (wdata),
                    .mask_r (m_a[e*NW+s])
                );
                mask_word #(
                    .VALID((s == SLOT_COMMON) ? 32'h0 : `MASK_B_BITS)
                ) u_b (
                    .mclk   (mclk),
                    .srst   (srst),
                    .set_we (wb && is_set),
                    .clr_we (wb && !is_set),  // [R1] [R19]
                    .wdata  (wdata),
                    .mask_r (m_b[e*NW+s])
                );
            end
        end
    endgenerate

    // ----------------------------------------
    // read path, one cycle latency
    // ----------------------------------------
    reg [31:0] rdata_nxt;
    always @* begin
        rdata_nxt = 32'h0;
        if (rd && hit) begin
            if (is_b) begin
                rdata_nxt = m_b[ev_sel*NW+slot];  // [R2] [R17]
            end else begin
                rdata_nxt = m_a[ev_sel*NW+slot];  // [R2] [R19]
            end
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            rdata <= 32'h0;
        end else begin
            rdata <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // raw status capture and event gating
    // ----------------------------------------
    // raw inputs come from other logic on mclk, so no synchroniser
    reg [3:0] ev_nxt;
    integer   ei, li;
    always @* begin
        ev_nxt = 4'h0;
        for (ei = 0; ei < `N_EVENTS; ei = ei + 1) begin
            if (|(raw_common_r & m_a[ei*NW+SLOT_COMMON])) ev_nxt[ei] = 1'b1;  // [R21]
            for (li = 0; li < N_LINKS; li = li + 1) begin
                if (ei < 2 || li == 0) begin
                    // ev2/3 share one mask over all links
                    if (|(raw_a_r[li*32 +: 32] & m_a[ei*NW+((ei < 2) ? li : 0)]))
                        ev_nxt[ei] = 1'b1;  // [R21] [R6] [R7] [R8]
                    if (|(raw_b_r[li*32 +: 32] & m_b[ei*NW+((ei < 2) ? li : 0)]))
                        ev_nxt[ei] = 1'b1;  // [R9] [R10] [R11] [R12] [R13] [R14] [R15]
                end else begin
                    if (|(raw_a_r[li*32 +: 32] & m_a[ei*NW]))
                        ev_nxt[ei] = 1'b1;
                    if (|(raw_b_r[li*32 +: 32] & m_b[ei*NW]))
                        ev_nxt[ei] = 1'b1;
                end
            end
        end
    end

    // raw status recorded whatever the mask says
    always @(posedge mclk) begin
        if (srst) begin
            raw_a_r           <= {N_LINKS*32{1'b0}};
            raw_b_r           <= {N_LINKS*32{1'b0}};
            raw_common_r      <= 32'h0;
            antenna_event_out <= 4'h0;
        end else begin
            raw_a_r           <= raw_a & {N_LINKS{`MASK_A_BITS}};  // [R21]
            raw_b_r           <= raw_b & {N_LINKS{`MASK_B_BITS}};
            raw_common_r      <= raw_common & `MASK_C_BITS;  // [R16]
            antenna_event_out <= ev_nxt;
        end
    end

endmodule // link_error_mask_clear

//--- hdl/mask_clear_defs.vh
`ifndef MASK_CLEAR_DEFS_VH
`define MASK_CLEAR_DEFS_VH

// ----------------------------------------
// geometry
// ----------------------------------------
`define N_LINKS        6
`define N_EVENTS       4
`define DATA_W         32
`define ADDR_W         12

// ----------------------------------------
// register map (byte addresses)
// per-link a/b for events 0,1: base + ev*0x100 + link*0x10 (+0x4 for b)
// shared a/b for events 2,3: base + ev*0x100 (+0x4 for b)
// common for every event: base + ev*0x100 + 0x80
// set aliases at +0x800 from the matching clear alias
// ----------------------------------------
`define OFF_EV_STRIDE  12'h100
`define OFF_LINK_STR   12'h010
`define OFF_A          12'h000
`define OFF_B          12'h004
`define OFF_COMMON     12'h080
`define OFF_SET        12'h800

// ----------------------------------------
// writable bits of each register
// ----------------------------------------
`define MASK_A_BITS    32'h1f11_ffff
`define MASK_B_BITS    32'h0117_370f
`define MASK_C_BITS    32'h03ff_f703

// ----------------------------------------
// field positions
// ----------------------------------------
`define A_RX_MASTER_FRAME_RANGE_ALARM  7
`define A_RX_FRAME_INDICATOR_LOST      6
`define A_RX_COMMA_MISSING             5
`define A_RX_BLOCK_EDGE_SEEN           4
`define A_RX_FRAME_EDGE_SEEN           3
`define A_RX_LINE_DECODE_ERROR         2
`define A_RX_SIGNAL_LOSS               1
`define A_RX_SYNC_CHANGE               0
`define B_ENCODER_CTRLWORD_KCHAR_ERROR 24
`define B_BUF_CIRCUIT_OUT_DMA_UNDERFLOW 20
`define B_BUF_OUT_BURST_OVERFLOW       18
`define B_BUF_CIRCUIT_OUT_DMA_OVERFLOW 17
`define B_BUF_CIRCUIT_IN_DMA_OVERFLOW  16
`define B_COMBINER_UNDERFLOW           13
`define B_COMBINER_OVERFLOW            12
`define B_AGGREGATOR_SUM_OVERFLOW      10
`define B_AGGREGATOR_FRAME_ALIGN_ERROR 9
`define B_AGGREGATOR_HEADER_ERROR      8
`define B_TX_HEADER_ERROR              3
`define B_TX_DATA_MISALIGNED           2
`define B_TX_FRAME_MISALIGNED          1
`define B_RX_SYNC_CHANGE               0
`define C_BUF_PACKET_OUT_FIFO_WRITE_ERROR 25
`define C_CAPTURE_RAM_BUS_ERROR        24

// ----------------------------------------
// reset value
// ----------------------------------------
`define MASK_RESET     32'h0000_0000

`endif

//--- hdl/mask_word.v
`timescale 1ns/100ps
`include "mask_clear_defs.vh"

// one enable-mask word, written through set and clear aliases
module mask_word #(
    parameter [31:0] VALID = 32'hffff_ffff
) (
    input  wire        mclk,
    input  wire        srst,
    input  wire        set_we,
    input  wire        clr_we,
    input  wire [31:0] wdata,
    output reg  [31:0] mask_r
);

    reg [31:0] mask_nxt;

    // ----------------------------------------
    // update
    // ----------------------------------------
    always @* begin
        mask_nxt = mask_r;
        if (clr_we) begin
            mask_nxt = mask_nxt & ~(wdata & VALID);  // [R1] [R20]
        end
        if (set_we) begin
            mask_nxt = mask_nxt | (wdata & VALID);   // [R18]
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            mask_r <= `MASK_RESET;  // [R17]
        end else begin
            mask_r <= mask_nxt & VALID;  // [R17]
        end
    end

endmodule // mask_word

//--- tb/mask_clear_chk.sv
`timescale 1ns/100ps
`include "mask_clear_defs.vh"
// ----------------
// port checker
// ----------------
module mask_clear_chk #(parameter N_LINKS = 6) (
    input logic                  mclk,
    input logic                  srst,
    input logic [11:0]           addr,
    input logic [31:0]           wdata,
    input logic                  wr,
    input logic                  rd,
    input logic [31:0]           rdata,
    input logic [N_LINKS*32-1:0] raw_a,
    input logic [N_LINKS*32-1:0] raw_b,
    input logic [31:0]           raw_common,
    input logic [N_LINKS*32-1:0] raw_a_r,
    input logic [N_LINKS*32-1:0] raw_b_r,
    input logic [31:0]           raw_common_r,
    input logic [3:0]            antenna_event_out
);
default clocking @(posedge mclk); endclocking
default disable iff (srst);
logic set_seen_r;
// no event can fire before any mask was ever set
always @(posedge mclk)
    if (srst) set_seen_r <= 1'b0;
    else if (wr && addr[11]) set_seen_r <= 1'b1;
a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata not zero outside read answer");
a_clr_read: assert property (wr && !addr[11] && wdata == 32'hffff_ffff
    ##1 rd && addr == $past(addr) |=> rdata == 32'h0)
    else $error("mask bits survive clear of all ones");
a_resv_zero: assert property ($past(rd) |-> (rdata & ~((($past(addr) & 12'h0ff) == 12'h080)
    ? `MASK_C_BITS : (($past(addr) & 12'h004) != 12'h0) ? `MASK_B_BITS : `MASK_A_BITS)) == 32'h0)
    else $error("reserved bit read as one");
a_raw_a_reg: assert property (!$past(srst) |->
    raw_a_r == ($past(raw_a) & {N_LINKS{`MASK_A_BITS}}))
    else $error("raw a status not recorded");
a_raw_b_reg: assert property (!$past(srst) |->
    raw_b_r == ($past(raw_b) & {N_LINKS{`MASK_B_BITS}}))
    else $error("raw b status not recorded");
a_raw_c_reg: assert property (!$past(srst) |->
    raw_common_r == ($past(raw_common) & `MASK_C_BITS))
    else $error("raw common status not recorded");
a_event_quiet: assert property (!set_seen_r |-> antenna_event_out == 4'h0)
    else $error("event before any mask set");
a_reset_clean: assert property ($fell(srst) |-> rdata == 32'h0 && antenna_event_out == 4'h0
    && raw_a_r == '0 && raw_common_r == 32'h0)
    else $error("outputs not clear after reset");
endmodule // mask_clear_chk
bind link_error_mask_clear mask_clear_chk #(.N_LINKS(N_LINKS)) i_mask_clear_chk (
    .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .raw_a(raw_a), .raw_b(raw_b), .raw_common(raw_common), .raw_a_r(raw_a_r),
    .raw_b_r(raw_b_r), .raw_common_r(raw_common_r), .antenna_event_out(antenna_event_out));

//--- tb/tb.sv
`timescale 1ns/100ps
`include "mask_clear_defs.vh"
module tb;
localparam NL = 6;
logic             mclk = 0, srst = 1, wr = 0, rd = 0, rd_d = 0;
logic [11:0]      addr = 0;
logic [31:0]      wdata = 0, raw_common = 0, rdata, raw_common_r;
logic [NL*32-1:0] raw_a = 0, raw_b = 0, raw_a_r, raw_b_r;
logic [3:0]       antenna_event_out;
logic [31:0]      m [4][NL][3];
logic [31:0]      exp_q [$];
int               fails = 0, tests_run = 0, seed = 35, e, l, k;
always #4 mclk = ~mclk;
link_error_mask_clear #(.N_LINKS(NL)) i_link_error_mask_clear (
    .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .raw_a(raw_a), .raw_b(raw_b), .raw_common(raw_common), .raw_a_r(raw_a_r),
    .raw_b_r(raw_b_r), .raw_common_r(raw_common_r), .antenna_event_out(antenna_event_out));
// ----------------
// helpers
// ----------------
function automatic logic [31:0] vm(int k);
    return k == 0 ? `MASK_A_BITS : k == 1 ? `MASK_B_BITS : `MASK_C_BITS;
endfunction
// shared words of events 2,3 and common words live at link 0
function automatic int li(int e, int l, int k);
    return (e > 1 || k == 2) ? 0 : l;
endfunction
function automatic logic [11:0] ad(int e, int l, int k);
    return 12'(e * 256 + (k == 2 ? 128 : li(e, l, k) * 16 + k * 4));
endfunction
function automatic logic [3:0] ev_exp();
    logic [3:0] r = 0;
    for (int e = 0; e < 4; e++) begin
        for (int l = 0; l < NL; l++) begin
            int j = e > 1 ? 0 : l;
            r[e] |= |(raw_a[l*32+:32] & m[e][j][0]) | |(raw_b[l*32+:32] & m[e][j][1]);
        end
        r[e] |= |(raw_common & m[e][0][2]);
    end
    return r;
endfunction
task automatic cmp(string n, logic [31:0] x, logic [31:0] g);
    tests_run++;
    if (g !== x) begin
        fails++;
        $display("BAD %s exp %h got %h", n, x, g);
    end
endtask
task automatic cmp_event(logic [3:0] x, logic [3:0] g);
    tests_run++;
    if (g !== x) begin
        fails++;
        $display("BAD event exp %h got %h", x, g);
    end
endtask
task automatic bus(bit w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w) exp_q.push_back(d);
endtask
task automatic put(int e, int l, int k, bit s, logic [31:0] d);
    m[e][li(e, l, k)][k] = s ? m[e][li(e, l, k)][k] | (d & vm(k)) : m[e][li(e, l, k)][k] & ~d;
    bus(1, ad(e, l, k) | (s ? 12'h800 : 12'h0), d);
endtask
task automatic get(int e, int l, int k);
    bus(0, ad(e, l, k), m[e][li(e, l, k)][k]);
endtask
task automatic idle(int n);
    repeat (n) begin
        @(posedge mclk);
        wr <= 0;
        rd <= 0;
    end
endtask
task automatic readall();
    for (int e = 0; e < 4; e++)
        for (int l = 0; l < NL; l++)
            for (int k = 0; k < 3; k++)
                get(e, l, k);
endtask
task automatic wrap_up();
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
// ----------------
// checking and stimulus
// ----------------
always @(posedge mclk) begin
    if (rd_d) cmp("rdata", exp_q.pop_front(), rdata);
    rd_d <= rd;
end
initial begin
    #50000;
    fails++;
    wrap_up();
end
initial begin
    m = '{default: 32'h0};
    repeat (6) @(posedge mclk);
    srst <= 0;
    readall();
    for (k = 0; k < 3; k++)
        for (int b = 0; b < 32; b++) begin
            put(1, 5, k, 1, 32'hffff_ffff);
            put(1, 5, k, 0, 32'h1 << b);
            get(1, 5, k);
        end
    put(1, 5, 0, 0, 32'hffff_ffff);
    get(1, 5, 0);
    bus(1, 12'h480, 32'hffff_ffff);
    bus(1, 12'hc80, 32'hffff_ffff);
    bus(0, 12'h480, 32'h0);
    for (int i = 0; i < 240; i++) begin
        e = $unsigned($random(seed)) % 4;
        l = $unsigned($random(seed)) % NL;
        k = $unsigned($random(seed)) % 3;
        put(e, l, k, i % 3 != 0, $random(seed));
        get(e, l, k);
        if (i % 6 == 5) begin
            // one raw bit per input vector so single mask bits decide the event
            raw_a <= (NL*32)'(1) << ($unsigned($random(seed)) % (NL * 32));
            raw_b <= (NL*32)'(1) << ($unsigned($random(seed)) % (NL * 32));
            raw_common <= 32'h1 << ($unsigned($random(seed)) % 32);
            idle(3);
            #1;
            cmp_event(ev_exp(), antenna_event_out);
        end
    end
    readall();
    idle(3);
    wrap_up();
end
endmodule // tb
